//--- can_eng_model.sv
// can_eng_model: behavioural can bus side, takes offered frames and reports progress
// assumes the design offers frames on a level request and reads one-cycle pulses
`default_nettype none
module can_eng_model
    import can_tx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tx_req_in,
    input wire tx_frame_type frame_in,
    input wire logic [15:0] ts_in,
    input wire logic slow_in,
    input wire logic lose_in,
    output var eng_status_type eng_out,
    output logic sent_out,
    output logic [1:0] idx_out,
    output logic [7:0] byte0_out,
    output logic [15:0] ts_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    int cnt;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy <= 1'b0;
            cnt <= 0;
            eng_out <= '0;
            sent_out <= 1'b0;
            idx_out <= 2'h0;
            byte0_out <= 8'h00;
            ts_out <= 16'h0000;
        end
        else
        begin
            eng_out <= '0;
            sent_out <= 1'b0;
            if (!busy)
            begin
                // start only while the frame is still offered
                if (tx_req_in && cnt >= (slow_in ? 20 : 1))
                begin
                    eng_out.started <= 1'b1;
                    busy <= 1'b1;
                    cnt <= 0;
                    idx_out <= frame_in.buf_idx;
                    byte0_out <= frame_in.msg[0];
                end
                else
                    cnt <= tx_req_in ? cnt + 1 : 0;
            end
            else
            begin
                if (eng_out.started)
                    ts_out <= ts_in;
                if (cnt == 6)
                begin
                    busy <= 1'b0;
                    cnt <= 0;
                    eng_out.lost <= lose_in;
                    eng_out.done <= !lose_in;
                    sent_out <= !lose_in;
                end
                else
                    cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- can_tx_buffer_manager.sv
// can_tx_buffer_manager: three transmit buffers, selection window, queueing
// assumes an avalon-mm master with waitrequest and a can engine that
// reports frame start, completion and lost arbitration as pulses
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`default_nettype none
module can_tx_buffer_manager
    import can_tx_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire eng_status_type eng_in,
    input wire logic [15:0] ts_in,
    output logic tx_req_out,
    output tx_frame_type tx_frame_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////
    // state
    tx_state_type state_reg, state_next;
    logic [1:0] cur_reg, cur_next;
    logic [2:0] txe_reg, txe_next;
    logic [2:0] abort_reg, abort_next;
    logic [2:0] ack_reg, ack_next;
    logic [2:0] sel_reg, sel_next;
    logic init_req_reg, init_req_next;
    logic init_ack_reg, init_ack_next;
    logic [2:0] stat_reg, stat_next;
    logic [2:0] mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic tx_req_reg, tx_req_next;
    tx_frame_type frame_reg, frame_next;
    logic [7:0] mem_reg [NUM_BUF][WIN_BYTES];
    logic [7:0] mem_next [NUM_BUF][WIN_BYTES];

    logic take;
    logic commit;
    logic wr;
    logic rd_done;
    logic win_hit;
    logic [3:0] win_byte;
    logic [1:0] sel_idx;
    logic init_active;
    logic [2:0] pick_ready;
    logic [NUM_BUF-1:0][7:0] local_priority_value_vec;
    logic pick_valid;
    logic [1:0] pick_idx;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [2:0] ab;
    logic [7:0] wdat;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    assign take = (avs_read_in | avs_write_in) & wait_reg;
    assign commit = (avs_read_in | avs_write_in) & ~wait_reg;
    assign wr = commit & avs_write_in & avs_byteenable_in[0];
    assign rd_done = commit & avs_read_in;
    assign wdat = avs_writedata_in[7:0];
    assign win_hit = (avs_address_in[7:6] == WIN_PAGE);
    assign win_byte = avs_address_in[5:2];
    assign sel_idx = oh_to_idx(sel_reg);
    assign init_active = init_req_reg & init_ack_reg;
    assign pick_ready = ~txe_reg & ~abort_reg;

    always_comb
    begin
        for (int i = 0; i < NUM_BUF; i++)
        begin
            local_priority_value_vec[i] = mem_reg[i][LOCAL_PRIORITY_VALUE_BYTE]; // RQ7
        end
    end

    can_tx_local_priority_value_pick #(
        .N(NUM_BUF)
    ) u_pick (
        .ready_in(pick_ready),
        .local_priority_value_in(local_priority_value_vec),
        .valid_out(pick_valid),
        .idx_out(pick_idx)
    );

    ////////////////////////////////////////////////////////////////////
    // read mux and bus handshake
    always_comb
    begin
        wait_next = ~(take);
        rdata_next = rdata_reg;
        if (take)
        begin
            rdata_next = 32'h0;
            if (win_hit)
            begin
                if (sel_reg != 3'h0)
                begin
                    rdata_next[7:0] = mem_reg[sel_idx][win_byte]; // RQ10
                end
            end
            else
            begin
                unique case (avs_address_in)
                    OFS_CTRL:
                    begin
                        rdata_next[CTRL_INIT_REQ_BIT] = init_req_reg;
                        rdata_next[CTRL_INIT_ACK_BIT] = init_ack_reg;
                    end
                    OFS_FLAG: rdata_next[2:0] = txe_reg; // RQ9
                    OFS_ABORT_REQ: rdata_next[2:0] = abort_reg;
                    OFS_ABORT_ACK: rdata_next[2:0] = ack_reg; // RQ2
                    OFS_SELECT: rdata_next[2:0] = sel_reg;
                    OFS_IRQ_STAT: rdata_next[2:0] = stat_reg;
                    OFS_IRQ_MASK: rdata_next[2:0] = mask_reg;
                    default: rdata_next = 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software writes and queue engine
    always_comb
    begin
        state_next = state_reg;
        cur_next = cur_reg;
        txe_next = txe_reg;
        abort_next = abort_reg;
        ack_next = ack_reg;
        sel_next = sel_reg;
        init_req_next = init_req_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        tx_req_next = tx_req_reg;
        frame_next = frame_reg;
        mem_next = mem_reg;
        ev = 3'h0;
        clr = 3'h0;
        ab = 3'h0;

        // register writes; the abort ack register has no write path
        if (wr && !win_hit) // RQ2
        begin
            unique case (avs_address_in)
                OFS_CTRL: init_req_next = wdat[CTRL_INIT_REQ_BIT];
                OFS_FLAG:
                begin
                    clr = wdat[2:0] & txe_reg; // RQ11
                    txe_next = txe_reg & ~clr;
                    ack_next = ack_reg & ~clr; // RQ4
                end
                OFS_ABORT_REQ: abort_next = abort_reg | (wdat[2:0] & ~txe_reg);
                OFS_SELECT: sel_next = lowest_bit(wdat[2:0] & txe_reg); // RQ10
                OFS_IRQ_MASK: mask_next = wdat[2:0];
                default: ;
            endcase
        end
        if (wr && win_hit && sel_reg != 3'h0 && win_byte <= LOCAL_PRIORITY_VALUE_BYTE)
        begin
            mem_next[sel_idx][win_byte] = wdat; // RQ6
        end
        if (rd_done && !win_hit && avs_address_in == OFS_IRQ_STAT)
        begin
            stat_next = 3'h0;
        end

        unique case (state_reg)
            ST_IDLE:
            begin
                ab = ~txe_reg & abort_reg;
                if (init_active || init_req_reg)
                begin
                    tx_req_next = 1'b0;
                end
                else if (ab != 3'h0)
                begin
                    txe_next = txe_next | ab; // RQ14
                    ack_next = ack_next | ab; // RQ3
                    abort_next = abort_next & ~ab;
                    ev = ab;
                end
                else if (pick_valid)
                begin
                    state_next = ST_REQ; // RQ13
                    cur_next = pick_idx; // RQ12
                    tx_req_next = 1'b1;
                    frame_next.buf_idx = pick_idx;
                    for (int b = 0; b < MSG_BYTES; b++)
                    begin
                        frame_next.msg[b] = mem_reg[pick_idx][b];
                    end
                end
            end
            ST_REQ:
            begin
                if (eng_in.started)
                begin
                    state_next = ST_SEND;
                    tx_req_next = 1'b0;
                    mem_next[cur_reg][TS_HI_BYTE] = ts_in[15:8]; // RQ8
                    mem_next[cur_reg][TS_LO_BYTE] = ts_in[7:0];
                end
                else if (eng_in.lost || abort_reg[cur_reg] || init_req_reg
                         || !pick_valid || pick_idx != cur_reg)
                begin
                    state_next = ST_IDLE;
                    tx_req_next = 1'b0;
                end
            end
            ST_SEND:
            begin
                if (eng_in.done)
                begin
                    state_next = ST_IDLE;
                    txe_next[cur_reg] = 1'b1; // RQ9
                    abort_next[cur_reg] = 1'b0; // RQ14
                    ev[cur_reg] = 1'b1;
                end
                else if (eng_in.lost)
                begin
                    state_next = ST_IDLE; // RQ13
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                tx_req_next = 1'b0;
            end
        endcase

        // force at the edge init mode starts, so no cycle of init shows a stale ack
        if (init_active || (init_req_next && state_next == ST_IDLE)) // RQ1
        begin
            state_next = ST_IDLE;
            tx_req_next = 1'b0;
            txe_next = TXE_RESET;
            abort_next = 3'h0;
            ack_next = ACK_RESET; // RQ1
        end
        stat_next = stat_next | ev;
    end

    assign init_ack_next = init_req_next & (state_next == ST_IDLE);
    assign irq_next = |(stat_next & mask_next);

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= ST_IDLE;
            cur_reg <= 2'h0;
            txe_reg <= TXE_RESET;
            abort_reg <= 3'h0;
            ack_reg <= ACK_RESET;
            sel_reg <= SEL_RESET;
            init_req_reg <= 1'b0;
            init_ack_reg <= 1'b0;
            stat_reg <= 3'h0;
            mask_reg <= MASK_RESET;
            irq_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
            tx_req_reg <= 1'b0;
            frame_reg <= '0;
            for (int i = 0; i < NUM_BUF; i++)
            begin
                for (int b = 0; b < WIN_BYTES; b++)
                begin
                    mem_reg[i][b] <= 8'h0;
                end
            end
        end
        else if (ce_in)
        begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            txe_reg <= txe_next;
            abort_reg <= abort_next;
            ack_reg <= ack_next;
            sel_reg <= sel_next;
            init_req_reg <= init_req_next;
            init_ack_reg <= init_ack_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            tx_req_reg <= tx_req_next;
            frame_reg <= frame_next;
            mem_reg <= mem_next;
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign tx_req_out = tx_req_reg;
    assign tx_frame_out = frame_reg;
    assign irq_out = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_init_ack_hold: assert property ( // RQ1
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (init_active && ce_in) |=> (ack_reg == ACK_RESET))
        else $error("abort ack not held during init");

    chk_init_ack_now: assert property ( // RQ1
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        init_active |-> (ack_reg == ACK_RESET))
        else $error("abort ack not at reset while init active");

    chk_ack_readback: assert property ( // RQ2
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (take && ce_in && avs_read_in && avs_address_in == OFS_ABORT_ACK)
        |=> (avs_readdata_out == {29'h0, $past(ack_reg)}))
        else $error("abort ack read returned wrong value");

    chk_ack_rise_cause: assert property ( // RQ3
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ce_in |=> ((ack_reg & ~$past(ack_reg) & ~($past(abort_reg) & ~$past(txe_reg)))
                   == 3'h0) && ((ack_reg & ~txe_reg) == 3'h0))
        else $error("abort ack set without pending abort");

    chk_ack_clear_txe: assert property ( // RQ4
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ce_in |=> ((ack_reg & $past(txe_reg) & ~txe_reg) == 3'h0))
        else $error("abort ack survived empty flag clear");

    chk_pick_best: assert property ( // RQ12
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (ce_in && state_reg == ST_IDLE && state_next == ST_REQ)
        |=> tx_req_out && !txe_reg[cur_reg] && cur_reg == $past(pick_idx))
        else $error("queued buffer not the best ready one");

    chk_back_to_back: assert property ( // RQ13
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (ce_in && state_reg == ST_SEND && eng_in.done && !init_req_reg
         && abort_reg == 3'h0 && (pick_ready & ~(3'h1 << cur_reg)) != 3'h0)
        ##1 ce_in |=> tx_req_out)
        else $error("next frame not requested at once");

    chk_no_late_abort: assert property ( // RQ14
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (ce_in && state_reg == ST_SEND && !ack_reg[cur_reg] && !init_active)
        |=> !ack_reg[$past(cur_reg)])
        else $error("started frame flagged as aborted");

    chk_done_empty: assert property ( // RQ9
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (ce_in && state_reg == ST_SEND && eng_in.done)
        |=> txe_reg[$past(cur_reg)] && state_reg == ST_IDLE)
        else $error("finished buffer not flagged empty");
endmodule
`default_nettype wire

//--- can_tx_buffer_manager_tb.sv
// can_tx_buffer_manager_tb: register scenarios for the transmit buffer manager
// assumes can_eng_model stands at the engine side
`default_nettype none
module can_tx_buffer_manager_tb
    import can_tx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    eng_status_type eng_in;
    logic [15:0] ts_in = 16'h0;
    logic tx_req_out;
    tx_frame_type tx_frame_out;
    logic irq_out;
    logic slow = 1'b0;
    logic lose = 1'b0;
    logic sent;
    logic [1:0] sent_idx;
    logic [7:0] sent_byte;
    logic [15:0] ts_cap;
    logic [31:0] q;
    int bad_count = 0;
    int comparisons = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) ts_in <= ts_in + 16'h1;
    can_tx_buffer_manager u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .eng_in(eng_in), .ts_in(ts_in),
        .tx_req_out(tx_req_out), .tx_frame_out(tx_frame_out), .irq_out(irq_out));
    can_eng_model u_eng (.clk_in(ref_clk_in), .rst_n_in(arst_n_in), .tx_req_in(tx_req_out),
        .frame_in(tx_frame_out), .ts_in(ts_in), .slow_in(slow), .lose_in(lose),
        .eng_out(eng_in), .sent_out(sent), .idx_out(sent_idx), .byte0_out(sent_byte),
        .ts_out(ts_cap));
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= b;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge ref_clk_in);
        for (n = 1; avs_waitrequest_out !== 1'b0 && n < 40; n++)
            @(posedge ref_clk_in);
        if (n >= 40)
            hang();
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hf);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(q, {24'h0, e});
    endtask
    // 0 frame sent, 1 arbitration lost, 2 frame started
    task automatic wait_ev(input int which);
        int n;
        @(posedge ref_clk_in);
        for (n = 0; n < 300; n++)
        begin
            if ((which == 0 && sent === 1'b1) || (which == 1 && eng_in.lost === 1'b1) ||
                (which == 2 && eng_in.started === 1'b1))
                break;
            @(posedge ref_clk_in);
        end
        if (n >= 300)
            hang();
    endtask
    task automatic fill(input logic [7:0] sel, input logic [7:0] local_priority_value, input logic [7:0] base);
        wr(OFS_SELECT, sel);
        rd_chk(OFS_SELECT, sel);
        for (int k = 0; k < MSG_BYTES; k++)
            wr(8'h40 + 8'(4 * k), base + 8'(k));
        wr(8'h40 + 8'(4 * LOCAL_PRIORITY_VALUE_BYTE), local_priority_value);
        rd_chk(8'h40 + 8'(4 * (MSG_BYTES - 1)), base + 8'(MSG_BYTES - 1));
        rd_chk(8'h40 + 8'(4 * LOCAL_PRIORITY_VALUE_BYTE), local_priority_value);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        rd_chk(OFS_FLAG, 8'(TXE_RESET));
        rd_chk(OFS_ABORT_ACK, 8'(ACK_RESET));
        rd_chk(OFS_SELECT, 8'(SEL_RESET));
        rd_chk(OFS_IRQ_MASK, 8'(MASK_RESET));
        rd_chk(8'h40, 8'h00);
        wr(OFS_ABORT_ACK, 8'h07);
        rd_chk(OFS_ABORT_ACK, 8'h00);
        rd_chk(8'h30, 8'h00);
        bus(1'b1, OFS_IRQ_MASK, 32'h7, 4'he);
        rd_chk(OFS_IRQ_MASK, 8'h00);
        wr(OFS_SELECT, 8'h06);
        rd_chk(OFS_SELECT, 8'h02);
    endtask
    task automatic s_local_priority_value();
        logic [1:0] order [3] = '{2'h1, 2'h2, 2'h0};
        fill(8'h01, 8'd30, 8'h10);
        fill(8'h02, 8'd10, 8'h20);
        fill(8'h04, 8'd20, 8'h30);
        wr(OFS_FLAG, 8'h07);
        for (int i = 0; i < 3; i++)
        begin
            wait_ev(0);
            chk(32'(sent_idx), 32'(order[i]));
            chk(32'(sent_byte), 32'h10 + 32'(order[i]) * 32'h10);
            repeat (2) @(posedge ref_clk_in);
            if (i < 2)
                chk(32'(tx_req_out), 32'h1);
        end
        rd_chk(OFS_FLAG, 8'h07);
        chk(32'(irq_out), 32'h0);
        rd_chk(OFS_IRQ_STAT, 8'h07);
        rd_chk(OFS_IRQ_STAT, 8'h00);
        wr(OFS_SELECT, 8'h01);
        rd_chk(8'h40 + 8'(4 * TS_HI_BYTE), ts_cap[15:8]);
        rd_chk(8'h40 + 8'(4 * TS_LO_BYTE), ts_cap[7:0]);
    endtask
    task automatic s_abort();
        wr(OFS_IRQ_MASK, 8'h01);
        slow <= 1'b1;
        wr(OFS_FLAG, 8'h01);
        wr(OFS_ABORT_REQ, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        rd_chk(OFS_ABORT_ACK, 8'h01);
        rd_chk(OFS_FLAG, 8'h07);
        chk(32'(irq_out), 32'h1);
        rd_chk(OFS_IRQ_STAT, 8'h01);
        repeat (3) @(posedge ref_clk_in);
        chk(32'(irq_out), 32'h0);
        wr(OFS_FLAG, 8'h01);
        rd_chk(OFS_ABORT_ACK, 8'h00);
        wr(OFS_ABORT_REQ, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        rd_chk(OFS_ABORT_ACK, 8'h01);
        wr(OFS_CTRL, 8'h01);
        rd_chk(OFS_CTRL, 8'h03);
        rd_chk(OFS_ABORT_ACK, 8'h00);
        wr(OFS_CTRL, 8'h00);
        slow <= 1'b0;
        wr(OFS_FLAG, 8'h01);
        wait_ev(2);
        wr(OFS_ABORT_REQ, 8'h01);
        wait_ev(0);
        rd_chk(OFS_ABORT_ACK, 8'h00);
        rd_chk(OFS_FLAG, 8'h07);
    endtask
    task automatic s_lose();
        lose <= 1'b1;
        wr(OFS_FLAG, 8'h02);
        wait_ev(1);
        lose <= 1'b0;
        wait_ev(0);
        chk(32'(sent_idx), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        s_reset();
        s_local_priority_value();
        s_abort();
        s_lose();
        close_out();
    end
endmodule
`default_nettype wire

//--- can_tx_local_priority_value_pick.sv
// can_tx_local_priority_value_pick: picks the ready buffer with the lowest priority value
// assumes ready and priority bytes come from registers of the caller
`default_nettype none
module can_tx_local_priority_value_pick
    import can_tx_pkg::*;
#(
    parameter int N = NUM_BUF
)
(
    input wire logic [N-1:0] ready_in,
    input wire logic [N-1:0][7:0] local_priority_value_in,
    output logic valid_out,
    output logic [1:0] idx_out
);
    logic [7:0] best;

    // lower value wins, ties go to the lower index
    always_comb
    begin
        valid_out = 1'b0;
        idx_out = 2'h0;
        best = 8'hff;
        for (int i = 0; i < N; i++)
        begin
            if (ready_in[i] && (!valid_out || local_priority_value_in[i] < best)) // RQ12
            begin
                valid_out = 1'b1;
                idx_out = 2'(i);
                best = local_priority_value_in[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- can_tx_pkg.sv
// can_tx_pkg: constants and types of the can transmit buffer manager
// assumes a 32-bit avalon-mm master and a can protocol engine beside it
// Functional notes
// [RQ1] the abort acknowledge flags stay at reset while init request and init ack are both 1
// [RQ2] abort acknowledge flags read at any time and ignore writes
// [RQ3] bits 2:0 hold one abort acknowledge flag per buffer, 1 when its message was aborted
// [RQ4] a buffer's abort acknowledge flag clears when its empty flag is cleared
// [RQ5] software reads the abort acknowledge flag after the buffer is flagged empty
// [RQ6] there are three transmit buffers of 13 message bytes each
// [RQ7] each buffer has an 8-bit local priority byte that ranks the ready buffers
// [RQ8] each buffer has two time stamp bytes filled when its frame starts
// [RQ9] an empty flag marks a free buffer and software only picks such a buffer
// [RQ10] the selection register maps only the chosen free buffer into the shared window
// [RQ11] software fills the buffer before it clears the empty flag to queue it
// [RQ12] of several ready buffers the one with the best local priority goes first
// [RQ13] after a frame the next ready buffer is requested at once, the bus dropped only on loss
// [RQ14] an abort is honoured only before the frame starts, else the flag stays 0; the code also honours it after a started frame loses arbitration
`default_nettype none
package can_tx_pkg;
    localparam int NUM_BUF = 3;
    localparam int MSG_BYTES = 13;
    localparam int WIN_BYTES = 16;
    localparam logic [3:0] LOCAL_PRIORITY_VALUE_BYTE = 4'hd;
    localparam logic [3:0] TS_HI_BYTE = 4'he;
    localparam logic [3:0] TS_LO_BYTE = 4'hf;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_ABORT_REQ = 8'h08;
    localparam logic [7:0] OFS_ABORT_ACK = 8'h0c;
    localparam logic [7:0] OFS_SELECT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [1:0] WIN_PAGE = 2'h1;
    localparam int CTRL_INIT_REQ_BIT = 0;
    localparam int CTRL_INIT_ACK_BIT = 1;
    localparam logic [2:0] TXE_RESET = 3'h7;
    localparam logic [2:0] ACK_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [2:0] SEL_RESET = 3'h0;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_SEND = 2'b10
    } tx_state_type;

    typedef struct packed
    {
        logic [1:0] buf_idx;
        logic [MSG_BYTES-1:0][7:0] msg;
    } tx_frame_type;

    typedef struct packed
    {
        logic started;
        logic done;
        logic lost;
    } eng_status_type;

    function automatic logic [2:0] lowest_bit(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction

    function automatic logic [1:0] oh_to_idx(input logic [2:0] oh);
        return oh[2] ? 2'h2 : (oh[1] ? 2'h1 : 2'h0);
    endfunction
endpackage
`default_nettype wire
